// ---- verilog/wrap_timer_pkg.sv ----
/*
 Shared constants and types for the free-running wrap timer: register word offsets, control
 field positions, reset values, tick source codes and the bus carrier structs.
 Assumes a single AHB-Lite master and one 20 MHz system clock.
*/
package wrap_timer_pkg;
   // byte addresses of the register words, one aligned word each
   localparam logic [7:0] OFS_COUNT_HIGH = 8'h00;
   localparam logic [7:0] OFS_COUNT_LOW = 8'h04;
   localparam logic [7:0] OFS_ALT_HIGH = 8'h08;
   localparam logic [7:0] OFS_ALT_LOW = 8'h0c;
   localparam logic [7:0] OFS_FLAGS = 8'h10;
   localparam logic [7:0] OFS_CTRL_FIRST = 8'h14;
   localparam logic [7:0] OFS_CTRL_SECOND = 8'h18;
   // field positions
   localparam int WRAP_FLAG_BIT = 5;
   localparam int WRAP_IRQ_ENABLE_BIT = 7;
   localparam int EXT_EDGE_SELECT_BIT = 0;
   localparam int TICK_SEL_LO = 2;
   // reset and reload values
   localparam logic [15:0] COUNT_RELOAD = 16'hfffc;
   localparam logic [15:0] COUNT_TOP = 16'hffff;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // tick source codes
   localparam logic [1:0] TICK_DIV4 = 2'h0;
   localparam logic [1:0] TICK_DIV2 = 2'h1;
   localparam logic [1:0] TICK_DIV8 = 2'h2;
   localparam logic [1:0] TICK_EXT = 2'h3;
   localparam logic [2:0] PRESCALE_RESET = 3'h0;
   // clock figures
   localparam int CLK_SYS_HZ = 20000000;
   localparam int EXT_MIN_FALLS = 4;

   typedef enum logic [1:0] {
      READ_LIVE = 2'b00,
      READ_HELD = 2'b01
   } low_read_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic write;
      logic valid;
   } bus_req_t;

   typedef struct packed {
      logic wrap_irq_enable;
      logic ext_edge_select;
      logic [1:0] tick_source_select;
   } timer_ctrl_t;
endpackage

// ---- verilog/tick_source.sv ----
/*
 Timer tick generator: prescaler by 2, 4 or 8 of the system clock, or a synchronised edge
 of the external tick pin. Assumes the pin is synchronous and slower than clk_sys / 4.
*/
`timescale 1ns/1ns
module tick_source (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic run,
   input wire wrap_timer_pkg::timer_ctrl_t ctrl,
   input wire logic ext_tick_pin,
   output logic tick
);
   import wrap_timer_pkg::*;

   logic [2:0] prescale_reg;
   logic ext_sync_reg;
   logic ext_prev_reg;
   logic ext_hold_reg;
   logic ext_edge;
   logic div_hit;

   // prescaler cleared by reset, frozen in halt
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         prescale_reg <= PRESCALE_RESET;
      end else if (run) begin
         prescale_reg <= prescale_reg + 3'h1;
      end
   end

   // pin sampled on the falling system edge, then moved into the rising domain
   always_ff @(negedge clk_sys or posedge reset) begin
      if (reset) begin
         ext_sync_reg <= 1'b0;
      end else begin
         ext_sync_reg <= ext_tick_pin;
      end
   end

   // only the second and third stages feed the edge logic, the first stage is read once, by ext_prev_reg
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ext_prev_reg <= 1'b0;
         ext_hold_reg <= 1'b0;
      end else begin
         ext_prev_reg <= ext_sync_reg;
         ext_hold_reg <= ext_prev_reg;
      end
   end

   // edge select: 1 rising, 0 falling
   assign ext_edge = ctrl.ext_edge_select ? (ext_prev_reg & ~ext_hold_reg)
                                          : (~ext_prev_reg & ext_hold_reg);

   // fixed code assignment of the three prescaler ratios
   always_comb begin
      case (ctrl.tick_source_select)
         TICK_DIV2: div_hit = prescale_reg[0];
         TICK_DIV4: div_hit = &prescale_reg[1:0];
         TICK_DIV8: div_hit = &prescale_reg;
         default: div_hit = ext_edge;
      endcase
   end

   assign tick = run & div_hit;
endmodule

// ---- verilog/wrap_timer.sv ----
/*
 Free-running 16-bit wrap timer with AHB-Lite register slave, two count views with buffered
 low byte, wrap flag with two-step clear and halt/wait behaviour.
 Assumes one AHB-Lite master, single word transfers, clk_sys at 20 MHz.
*/
// The AHB-Lite register port and the register offsets were chosen for this implementation.
// Operation
// - sixteen-bit up counter advancing once per tick, read as high and low byte.
// - tick is clock by 2, 4, 8 or external pin per select bits.
// - primary and alternate count views return the same value.
// - writing either low byte forces the count to fffc.
// - count resets to fffc, the only value ever reloaded.
// - high byte read captures the low byte into a buffer.
// - buffered low byte stays frozen until the low byte is read.
// - low byte read without high byte read returns the live low byte.
// - wrap from ffff to 0000 sets the wrap flag.
// - interrupt asserted while flag, enable set and cpu mask clear; otherwise pending.
// - flag cleared by flags read while set, then primary low byte access.
// - alternate low byte accesses never clear the wrap flag.
// - wait mode leaves the counter running unchanged.
// - halt stops the count; it resumes from held value, reset restarts.
// - both select bits one picks external tick; edge bit picks its transition.
// - external edge is synchronised on the falling cpu clock edge.
`timescale 1ns/1ns
module wrap_timer (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic cpu_irq_mask,
   input wire logic halt_mode,
   input wire logic wait_mode,
   input wire logic ext_tick_pin,
   output logic timer_irq,
   output logic [15:0] count_now
);
   import wrap_timer_pkg::*;

   logic [15:0] count_reg;
   logic [7:0] low_buffer_reg;
   low_read_state_t low_state_reg;
   logic wrap_flag_reg;
   logic flag_seen_reg;
   logic [7:0] ctrl_first_reg;
   logic [7:0] ctrl_second_reg;
   bus_req_t req_reg;
   logic [31:0] rdata_reg;
   timer_ctrl_t ctrl;
   logic tick;
   logic run;
   logic wrap;
   logic addr_ok;
   logic rd;
   logic wr;
   logic low_access;
   logic primary_low_access;
   logic high_take;
   logic low_take;
   logic rd_take;
   logic reload;
   logic [7:0] take_addr;
   logic flags_read;

   function automatic logic is_view(input logic [7:0] a, input logic [7:0] prim, input logic [7:0] alt);
      is_view = (a == prim) || (a == alt);
   endfunction

   // byte address of the aligned register word
   function automatic logic [7:0] word_addr(input logic [31:0] a);
      word_addr = {a[7:2], 2'b00};
   endfunction

   // wait mode is not an input to anything below: the counter simply keeps going
   assign run = ~halt_mode;
   assign ctrl.wrap_irq_enable = ctrl_first_reg[WRAP_IRQ_ENABLE_BIT];
   assign ctrl.ext_edge_select = ctrl_second_reg[EXT_EDGE_SELECT_BIT];
   assign ctrl.tick_source_select = ctrl_second_reg[TICK_SEL_LO +: 2];

   tick_source u_tick (
      .clk_sys(clk_sys),
      .reset(reset),
      .run(run),
      .ctrl(ctrl),
      .ext_tick_pin(ext_tick_pin),
      .tick(tick)
   );

   // address phase capture; slave is always ready so every phase lasts one cycle
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         req_reg <= '0;
      end else if (hready) begin
         req_reg.valid <= hsel & htrans[1];
         req_reg.write <= hwrite;
         req_reg.addr <= word_addr(haddr);
      end
   end

   // data phase decode, side effects fire once in the data phase
   assign addr_ok = req_reg.valid;
   assign rd = addr_ok & ~req_reg.write;
   assign wr = addr_ok & req_reg.write;
   assign low_access = addr_ok & is_view(req_reg.addr, OFS_COUNT_LOW, OFS_ALT_LOW);
   assign primary_low_access = addr_ok & (req_reg.addr == OFS_COUNT_LOW);
   assign flags_read = rd & (req_reg.addr == OFS_FLAGS);
   assign reload = wr & low_access;
   // a reload in the same cycle wins, so that tick is no wrap
   assign wrap = tick & (count_reg == COUNT_TOP) & ~reload;

   // address phase decode: the low byte snapshot is taken at the same edge as the high byte read data
   assign take_addr = word_addr(haddr);
   assign rd_take = hready & hsel & htrans[1] & ~hwrite;
   assign high_take = rd_take & is_view(take_addr, OFS_COUNT_HIGH, OFS_ALT_HIGH);
   assign low_take = rd_take & is_view(take_addr, OFS_COUNT_LOW, OFS_ALT_LOW);

   // counter; a low byte write takes priority over a tick in the same cycle
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         count_reg <= COUNT_RELOAD;
      end else if (reload) begin
         count_reg <= COUNT_RELOAD;
      end else if (tick) begin
         count_reg <= count_reg + 16'h0001;
      end
   end
   assign count_now = count_reg;

   // low byte buffer: armed by a high read, released by a low read; snapping it with the
   // high byte keeps a carry between the two reads from tearing the 16-bit value
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         low_state_reg <= READ_LIVE;
         low_buffer_reg <= 8'h00;
      end else begin
         case (low_state_reg)
            READ_LIVE: begin
               if (high_take) begin
                  low_buffer_reg <= count_reg[7:0];
                  low_state_reg <= READ_HELD;
               end
            end
            READ_HELD: begin
               if (low_take) begin
                  low_state_reg <= READ_LIVE;
               end
            end
            default: low_state_reg <= READ_LIVE;
         endcase
      end
   end

   // wrap flag with two-step clear; a new wrap beats the clear
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wrap_flag_reg <= 1'b0;
         flag_seen_reg <= 1'b0;
      end else begin
         if (wrap) begin
            wrap_flag_reg <= 1'b1;
         end else if (flag_seen_reg && primary_low_access) begin
            wrap_flag_reg <= 1'b0;
         end
         if (flags_read && wrap_flag_reg) begin
            flag_seen_reg <= 1'b1;
         end else if (primary_low_access) begin
            flag_seen_reg <= 1'b0;
         end
      end
   end

   // pending request shows as soon as enable set and cpu mask clear
   assign timer_irq = wrap_flag_reg & ctrl.wrap_irq_enable & ~cpu_irq_mask;

   // control registers
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ctrl_first_reg <= CTRL_RESET;
         ctrl_second_reg <= CTRL_RESET;
      end else if (wr && req_reg.addr == OFS_CTRL_FIRST) begin
         ctrl_first_reg <= hwdata[7:0];
      end else if (wr && req_reg.addr == OFS_CTRL_SECOND) begin
         ctrl_second_reg <= hwdata[7:0];
      end
   end

   // read mux registered at the address phase so hrdata comes from a flop
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rdata_reg <= 32'h0000_0000;
      end else if (rd_take) begin
         case (take_addr)
            OFS_COUNT_HIGH, OFS_ALT_HIGH: rdata_reg <= {24'h000000, count_reg[15:8]};
            OFS_COUNT_LOW, OFS_ALT_LOW: begin
               if (low_state_reg == READ_HELD) begin
                  rdata_reg <= {24'h000000, low_buffer_reg};
               end else begin
                  rdata_reg <= {24'h000000, count_reg[7:0]};
               end
            end
            OFS_FLAGS: rdata_reg <= 32'(wrap_flag_reg) << WRAP_FLAG_BIT;
            OFS_CTRL_FIRST: rdata_reg <= {24'h000000, ctrl_first_reg};
            OFS_CTRL_SECOND: rdata_reg <= {24'h000000, ctrl_second_reg};
            default: rdata_reg <= 32'h0000_0000;
         endcase
      end
   end
   assign hrdata = rdata_reg;

   // checks
   chk_reload_value: assert property (@(posedge clk_sys) disable iff (reset)
      (wr && low_access) |=> count_reg == COUNT_RELOAD) else $error("low write did not reload");
   chk_wrap_sets: assert property (@(posedge clk_sys) disable iff (reset)
      wrap |=> wrap_flag_reg && count_reg == 16'h0000) else $error("wrap did not set flag");
   chk_alt_keeps: assert property (@(posedge clk_sys) disable iff (reset)
      (addr_ok && req_reg.addr == OFS_ALT_LOW && wrap_flag_reg) |=> wrap_flag_reg)
      else $error("alternate access cleared flag");
   chk_clear_needs: assert property (@(posedge clk_sys) disable iff (reset)
      $fell(wrap_flag_reg) |-> $past(flag_seen_reg) && $past(primary_low_access))
      else $error("flag cleared without sequence");
   chk_halt_holds: assert property (@(posedge clk_sys) disable iff (reset)
      (halt_mode && !(wr && low_access)) |=> $stable(count_reg)) else $error("count moved in halt");
   chk_irq_gate: assert property (@(posedge clk_sys) disable iff (reset)
      timer_irq == (wrap_flag_reg && ctrl_first_reg[WRAP_IRQ_ENABLE_BIT] && !cpu_irq_mask))
      else $error("irq gating wrong");
   chk_buffer_frozen: assert property (@(posedge clk_sys) disable iff (reset)
      (low_state_reg == READ_HELD && !(rd && low_access)) |=> $stable(low_buffer_reg))
      else $error("buffered low byte changed");
   chk_div2_rate: assert property (@(posedge clk_sys) disable iff (reset)
      (tick && run && ctrl.tick_source_select == TICK_DIV2 && !halt_mode) |=> !tick)
      else $error("divide by two ticked twice");
   chk_snap_low: assert property (@(posedge clk_sys) disable iff (reset)
      (high_take && low_state_reg == READ_LIVE) |=> low_state_reg == READ_HELD && low_buffer_reg == $past(count_reg[7:0]))
      else $error("low byte not snapped with high read");
   chk_live_low: assert property (@(posedge clk_sys) disable iff (reset)
      (low_take && low_state_reg == READ_LIVE) |=> hrdata[7:0] == $past(count_reg[7:0]))
      else $error("lone low read not live");
   chk_count_step: assert property (@(posedge clk_sys) disable iff (reset)
      (tick && !reload) |=> count_reg == $past(count_reg) + 16'h0001)
      else $error("count did not step by one");
   chk_halt_no_tick: assert property (@(posedge clk_sys) disable iff (reset)
      halt_mode |-> !tick)
      else $error("tick while halted");
endmodule

// ---- bench/ext_tick_model.sv ----
/*
 Far-side model of the external tick source: a slow square wave on the tick pin.
 Assumes the bench enables it only while the external tick source is selected.
*/
`timescale 1ns/1ns
module ext_tick_model (
   input wire logic clk_sys,
   input wire logic run,
   output logic ext_tick_pin
);
   logic [2:0] span_reg;

   // toggle every 8 cycles, so active edges are 16 cycles apart; the pin rests low when idle
   always_ff @(posedge clk_sys) begin
      span_reg <= run ? span_reg + 3'h1 : 3'h0;
      if (!run) begin
         ext_tick_pin <= 1'b0;
      end else if (span_reg == 3'h7) begin
         ext_tick_pin <= ~ext_tick_pin;
      end
   end
endmodule

// ---- bench/free_running_timer_counter_bench.sv ----
/*
 Self-checking bench for the wrap timer: AHB-Lite read and write tasks, tick rate,
 16-bit buffered read, wrap flag and interrupt checks.
 Assumes a zero-wait slave and the external tick model beside it.
*/
`timescale 1ns/1ns
module free_running_timer_counter_bench;
   import wrap_timer_pkg::*;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, timer_irq, ext_run = 1'b0, ext_pin;
   logic cpu_irq_mask = 1'b1, halt_mode = 1'b0, wait_mode = 1'b0;
   logic [15:0] count_now;
   int fails = 0, checks_done = 0;
   logic [31:0] rd, hi, lo;
   logic [15:0] d;
   logic [1:0] sel_tab[5] = '{TICK_DIV4, TICK_DIV2, TICK_DIV8, TICK_EXT, TICK_EXT};
   int cyc_tab[5] = '{64, 64, 64, 160, 160};
   int exp_tab[5] = '{16, 32, 8, 10, 10};

   always #25 clk_sys = ~clk_sys;

   wrap_timer dut_u (.clk_sys(clk_sys), .reset(reset), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .cpu_irq_mask(cpu_irq_mask), .halt_mode(halt_mode),
      .wait_mode(wait_mode), .ext_tick_pin(ext_pin), .timer_irq(timer_irq), .count_now(count_now));

   ext_tick_model partner_u (.clk_sys(clk_sys), .run(ext_run), .ext_tick_pin(ext_pin));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one single transfer; every phase waits for hready under a bound
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
      int n;
      @(posedge clk_sys);
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      n = 0;
      do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 50);
      htrans <= 2'h0;
      hwdata <= wd;
      n = 0;
      do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 50);
      rd = hrdata;
      chk({31'h0, hresp}, 32'h0);
   endtask

   task automatic read16(input logic [7:0] base);
      xfer(base, 1'b0, 32'h0);
      hi = rd;
      xfer(base + 8'h04, 1'b0, 32'h0);
      lo = rd;
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // watchdog sized well above the fewer than one thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_sys);
      fails++;
      end_of_test;
   end

   initial begin
      repeat (20) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      chk({16'h0, count_now}, {16'h0, COUNT_RELOAD});
      chk({31'h0, timer_irq}, 32'h0);
      xfer(8'h1c, 1'b0, 32'h0);
      chk(rd, 32'h0);
      // tick rate per source; counting from the reload also wraps every time
      for (int i = 0; i < 5; i++) begin
         halt_mode <= 1'b1;
         wait_mode <= (i == 0);
         xfer(OFS_CTRL_SECOND, 1'b1, {28'h0, sel_tab[i], 1'b0, i == 3});
         xfer(OFS_ALT_LOW, 1'b1, 32'h0000005a);
         read16(OFS_ALT_HIGH);
         chk({hi[7:0], lo[7:0]}, {16'h0, COUNT_RELOAD});
         @(posedge clk_sys);
         halt_mode <= 1'b0;
         ext_run <= (i > 2);
         repeat (cyc_tab[i]) @(posedge clk_sys);
         halt_mode <= 1'b1;
         ext_run <= 1'b0;
         read16(OFS_ALT_HIGH);
         d = {hi[7:0], lo[7:0]} - COUNT_RELOAD;
         chk(32'(d + 2 >= exp_tab[i] && d <= exp_tab[i] + 2), 32'h1);
         xfer(OFS_ALT_LOW, 1'b0, 32'h0);
         chk(rd, lo);
      end
      // wrap flag survives alternate accesses and is held pending under the mask
      xfer(OFS_CTRL_FIRST, 1'b1, 32'h00000080);
      @(posedge clk_sys);
      chk({31'h0, timer_irq}, 32'h0);
      cpu_irq_mask <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk({31'h0, timer_irq}, 32'h1);
      xfer(OFS_FLAGS, 1'b0, 32'h0);
      chk(rd & 32'h20, 32'h20);
      xfer(OFS_ALT_LOW, 1'b0, 32'h0);
      xfer(OFS_FLAGS, 1'b0, 32'h0);
      chk(rd & 32'h20, 32'h20);
      xfer(OFS_COUNT_LOW, 1'b0, 32'h0);
      xfer(OFS_FLAGS, 1'b0, 32'h0);
      chk(rd & 32'h20, 32'h0);
      chk({31'h0, timer_irq}, 32'h0);
      // buffered low byte across counting and a repeated high read
      xfer(OFS_CTRL_SECOND, 1'b1, {28'h0, TICK_DIV2, 2'h0});
      xfer(OFS_COUNT_LOW, 1'b1, 32'h00000033);
      xfer(OFS_COUNT_HIGH, 1'b0, 32'h0);
      chk(rd, 32'h000000ff);
      halt_mode <= 1'b0;
      repeat (40) @(posedge clk_sys);
      halt_mode <= 1'b1;
      xfer(OFS_COUNT_HIGH, 1'b0, 32'h0);
      xfer(OFS_COUNT_LOW, 1'b0, 32'h0);
      chk(rd, 32'h000000fc);
      xfer(OFS_COUNT_LOW, 1'b0, 32'h0);
      lo = rd;
      chk(32'(lo != 32'hfc), 32'h1);
      d = lo[15:0];
      read16(OFS_ALT_HIGH);
      chk(lo, {16'h0, d});
      // reset while halted: the held count is dropped and the flag set by the last wrap is cleared
      reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      chk({16'h0, count_now}, {16'h0, COUNT_RELOAD});
      xfer(OFS_FLAGS, 1'b0, 32'h0);
      chk(rd, 32'h0);
      end_of_test;
   end
endmodule
